// ---- hdl/rcb_pkg.sv ----
// rcb_pkg: constants for the dual-bank relay carrier port logic
// assumes one 200 MHz clock domain; all pins synchronised in the top
`default_nettype none
package rcb_pkg;
    localparam int BANK_W = 8;
    localparam int ADDR_W = 5;
    localparam int SW_W = 4;
    localparam logic [ADDR_W-1:0] BANK_ZERO_PORT_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] BANK_ONE_PORT_OFS = 5'h01;
    localparam int SW_LSB_POS = 1;
    localparam logic [BANK_W-1:0] LATCH_RST = 8'h00;
    localparam logic DIR_INPUT = 1'b1;
    localparam logic WDOG_ENABLE = 1'b1;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        RCB_IDLE = 2'b00,
        RCB_STROBE = 2'b01,
        RCB_HOLD = 2'b10
    } rcb_wstate_t;
endpackage
`default_nettype wire

// ---- hdl/rcb_sync.sv ----
// rcb_sync: two-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to clk
`default_nettype none
module rcb_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rcb_sync_t;
    rcb_sync_t st, next_st;
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign q = st.s2;
endmodule // rcb_sync
`default_nettype wire

// ---- hdl/rcb_carrier.sv ----
// rcb_carrier: two-bank relay carrier expansion-port logic
// assumes host holds address, direction and data stable around strobes
//
// Functional notes
// [R1] two independent eight-bit banks, one bit per relay module position
// [R2] each bank's jumper alone sets the whole bank input or output
// [R3] base address from switches weighted 16,8,4,2; banks at base+0, base+1
// [R4] host keeps up to 16 boards on distinct switch settings
// [R5] watchdog on: power loss clears latches and floats outputs
// [R6] watchdog on: outputs stay disabled after power returns until a write
// [R7] watchdog off: power loss leaves latches intact, writes still accepted
// [R8] watchdog off: outputs follow latches again as soon as power returns
// [R9] watchdog affects output banks only; input data valid on power return
// [R10] watchdog counts as enabled unless its jumper selects disable
// [R11] output banks get load strobes clocking host data into registers
// [R12] expansion port passes through two chained connectors unchanged
// [R13] answer only own bank addresses; drive read data only for input banks
// [R14] host holds address and data stable around its strobes
`default_nettype none
module rcb_carrier
    import rcb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [rcb_pkg::SW_W-1:0] board_address_switch,
    input wire logic bank_zero_direction_jumper,
    input wire logic bank_one_direction_jumper,
    input wire logic power_watchdog_jumper,
    input wire logic ext_power_good,
    input wire logic [rcb_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_wr_n,
    input wire logic bus_rd_n,
    input wire logic [rcb_pkg::BANK_W-1:0] bus_data_in,
    output logic [rcb_pkg::BANK_W-1:0] bus_data_out,
    output logic bus_data_oe_n,
    input wire logic [rcb_pkg::BANK_W-1:0] bank_zero_in,
    input wire logic [rcb_pkg::BANK_W-1:0] bank_one_in,
    output logic [rcb_pkg::BANK_W-1:0] bank_zero_out,
    output logic [rcb_pkg::BANK_W-1:0] bank_one_out,
    output logic [1:0] bank_out_oe_n,
    output logic [1:0] bank_load_strobe
);
    import rcb_pkg::*;

    // address decode used for read and write paths
    function automatic logic [1:0] bank_hit(input logic [ADDR_W-1:0] a,
                                            input logic [SW_W-1:0] sw);
        logic [ADDR_W-1:0] base;
        base = {sw, 1'b0};
        bank_hit[0] = (a == (base | BANK_ZERO_PORT_OFS)); // R3
        bank_hit[1] = (a == (base | BANK_ONE_PORT_OFS)); // R3
    endfunction

    // reset release through two flops
    logic [1:0] rst_sh;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sh <= 2'b00;
        end else begin
            rst_sh <= {rst_sh[0], 1'b1};
        end
    end
    assign rst_n = rst_sh[1];

    // all pins are asynchronous: 4+1+1+1+1+5+2+8+16 bits
    localparam int SW = SW_W + 4 + ADDR_W + 2 + BANK_W + 2 * BANK_W;
    logic [SW-1:0] s;
    // raw reset here: the pipe fills while the release is in flight, no false strobe edge
    rcb_sync #(.W(SW)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({board_address_switch, bank_zero_direction_jumper, bank_one_direction_jumper,
            power_watchdog_jumper, ext_power_good, bus_addr, bus_wr_n, bus_rd_n,
            bus_data_in, bank_zero_in, bank_one_in}),
        .q(s)
    );
    logic [SW_W-1:0] sw_s;
    logic [1:0] dir_in;
    logic wdog_en, pwr_ok, wr_n_s, rd_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [BANK_W-1:0] din_s;
    logic [BANK_W-1:0] pin_s [2];
    assign {sw_s, dir_in[0], dir_in[1], wdog_en, pwr_ok, addr_s, wr_n_s, rd_n_s,
            din_s, pin_s[0], pin_s[1]} = s;

    typedef struct packed {
        logic wr_d;
        logic [1:0][BANK_W-1:0] latch;
        logic [1:0] armed;
        logic [1:0] strobe;
        logic [1:0][BANK_W-1:0] pout;
        logic [1:0] oe_n;
        logic [BANK_W-1:0] rdata;
        logic rd_oe_n;
        rcb_wstate_t ws;
    } rcb_state_t;
    rcb_state_t st, next_st;

    logic [1:0] hit;
    logic wr_edge;
    assign hit = bank_hit(addr_s, sw_s);
    assign wr_edge = st.wr_d && !wr_n_s;

    always_comb begin
        next_st = st;
        next_st.wr_d = wr_n_s;
        next_st.strobe = 2'b00;
        // one write accepted per falling strobe edge; wait for release
        case (st.ws)
            RCB_IDLE: begin
                if (wr_edge) begin
                    next_st.ws = RCB_STROBE;
                end
            end
            RCB_STROBE: begin
                next_st.ws = RCB_HOLD;
            end
            RCB_HOLD: begin
                if (wr_n_s) begin
                    next_st.ws = RCB_IDLE;
                end
            end
            default: begin
                next_st.ws = RCB_IDLE;
            end
        endcase
        for (int b = 0; b < 2; b++) begin
            // R1 R2: per-bank, only output banks accept data
            if (st.ws == RCB_IDLE && wr_edge && hit[b] && dir_in[b] != DIR_INPUT) begin
                next_st.latch[b] = din_s; // R11 R7
                next_st.strobe[b] = 1'b1; // R11
                next_st.armed[b] = 1'b1; // R6
            end
            // watchdog enabled unless jumper says otherwise
            if (!pwr_ok && wdog_en == WDOG_ENABLE) begin // R10
                next_st.latch[b] = LATCH_RST; // R5
                next_st.strobe[b] = 1'b0; // R5
                next_st.armed[b] = 1'b0; // R5 R6
            end
            if (wdog_en != WDOG_ENABLE) begin
                next_st.armed[b] = 1'b1; // R7 R8
            end
            next_st.pout[b] = st.latch[b];
            // outputs float while unpowered, input banks, or not yet re-armed
            next_st.oe_n[b] = !(pwr_ok && st.armed[b] && dir_in[b] != DIR_INPUT); // R5 R8 R9
        end
        // input reads pass straight through whether or not power is good
        next_st.rd_oe_n = 1'b1;
        next_st.rdata = 8'h00;
        for (int b = 0; b < 2; b++) begin
            if (!rd_n_s && hit[b] && dir_in[b] == DIR_INPUT) begin // R13
                next_st.rd_oe_n = 1'b0;
                next_st.rdata = pin_s[b]; // R9
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{wr_d: 1'b1, latch: '0, armed: 2'b00, strobe: 2'b00, pout: '0,
                    oe_n: 2'b11, rdata: 8'h00, rd_oe_n: 1'b1, ws: RCB_IDLE};
        end else begin
            st <= next_st;
        end
    end

    // connectors are wired in parallel on the board, no logic needed
    assign bus_data_out = st.rdata; // R12
    assign bus_data_oe_n = st.rd_oe_n;
    assign bank_zero_out = st.pout[0];
    assign bank_one_out = st.pout[1];
    assign bank_out_oe_n = st.oe_n;
    assign bank_load_strobe = st.strobe;

    // checks
    wdog_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!pwr_ok && wdog_en) |=> st.latch == '0 && st.armed == 2'b00) // R5
        else $error("latches not cleared on power loss");
    stay_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!st.armed[0]) |=> bank_out_oe_n[0]) // R6
        else $error("bank zero enabled before rearm");
    keep_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wdog_en && !wr_edge) |=> st.latch == $past(st.latch)) // R7
        else $error("latch changed without write");
    drive_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wdog_en && $past(!wdog_en) && pwr_ok && dir_in[1] != DIR_INPUT
         && $past(dir_in[1] != DIR_INPUT)) |=> !bank_out_oe_n[1]) // R8
        else $error("bank one not driven on power return");
    input_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        (dir_in[0] == DIR_INPUT) |=> bank_out_oe_n[0]) // R2 R9
        else $error("input bank driven");
    strobe_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        bank_load_strobe[1] |-> st.latch[1] == $past(din_s) && !bank_load_strobe[0]) // R11
        else $error("strobe without matching data");
    strobe_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        bank_load_strobe[0] |=> !bank_load_strobe[0]) // R11
        else $error("strobe longer than one cycle");
    read_own_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_data_oe_n |-> $past(!rd_n_s && (hit & dir_in) != 2'b00)) // R13
        else $error("read answered for foreign address");
    addr_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit[1] |-> addr_s == {sw_s, 1'b1}) // R3
        else $error("bank one decode wrong");
    write_cov_c: cover property (@(posedge clk) disable iff (!rst_n) bank_load_strobe[0]);
    read_cov_c: cover property (@(posedge clk) disable iff (!rst_n) !bus_data_oe_n);
    rearm_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
        !st.armed[1] ##1 st.armed[1]);
endmodule // rcb_carrier
`default_nettype wire

// ---- test/rcb_host_model.sv ----
// rcb_host_model: host end of the expansion port, one task per bus cycle
// assumes the carrier passes its strobes through two sync flops
`default_nettype none
module rcb_host_model
    import rcb_pkg::*;
(
    input wire logic clk,
    output var logic [rcb_pkg::ADDR_W-1:0] bus_addr = 5'h1F,
    output var logic bus_wr_n = 1'b1,
    output var logic bus_rd_n = 1'b1,
    output var logic [rcb_pkg::BANK_W-1:0] bus_data_in = 8'h00,
    input wire logic [rcb_pkg::BANK_W-1:0] bus_data_out,
    input wire logic bus_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // three edges of setup cover the sync lag; five edges low outlast the load
    task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe);
        @(posedge clk);
        bus_addr <= a;
        bus_data_in <= d;
        repeat (3) @(posedge clk);
        if (we) bus_wr_n <= 1'b0;
        else bus_rd_n <= 1'b0;
        repeat (4) @(posedge clk);
        // sample mid-cycle, where registered answers have settled
        @(negedge clk);
        q = bus_data_out;
        oe = bus_data_oe_n;
        @(posedge clk);
        bus_wr_n <= 1'b1;
        bus_rd_n <= 1'b1;
        bus_data_in <= ~d; // released bus must not keep showing the old byte
    endtask
endmodule // rcb_host_model
`default_nettype wire

// ---- test/rcb_carrier_test.sv ----
// rcb_carrier_test: self-checking bench with a reference model of both banks
// assumes rcb_host_model performs every expansion-port cycle
`default_nettype none
module rcb_carrier_test;
    import rcb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, wdog = WDOG_ENABLE, pg = 1'b1, oe, wr_n, rd_n, doe_n;
    logic [1:0] dir = 2'b00, oe_n, stb;
    logic [3:0] sw = 4'h0;
    logic [4:0] addr, base;
    logic [7:0] din, dout, in0 = 8'h5A, in1 = 8'hA5, out0, out1, rdv, v;
    int error_cnt, n_compared, cyc, seed = 32'h3a2f959f, nstb[2], estb[2], lat[2], arm[2];
    rcb_carrier u_dut (.clk(clk), .resetn(resetn), .board_address_switch(sw),
        .bank_zero_direction_jumper(dir[0]), .bank_one_direction_jumper(dir[1]),
        .power_watchdog_jumper(wdog), .ext_power_good(pg), .bus_addr(addr), .bus_wr_n(wr_n),
        .bus_rd_n(rd_n), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(doe_n),
        .bank_zero_in(in0), .bank_one_in(in1), .bank_zero_out(out0), .bank_one_out(out1),
        .bank_out_oe_n(oe_n), .bank_load_strobe(stb));
    rcb_host_model u_host (.clk(clk), .bus_addr(addr), .bus_wr_n(wr_n), .bus_rd_n(rd_n),
        .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(doe_n));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        nstb[0] += int'(stb[0]);
        nstb[1] += int'(stb[1]);
        if (++cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wrb(input int b);
        v = 8'($random(seed));
        u_host.bus(1'b1, base + 5'(b), v, rdv, oe);
        if (dir[b] != DIR_INPUT) begin
            lat[b] = v;
            arm[b] = 1;
            estb[b]++;
        end
    endtask
    // settle time covers the sync lag on power and jumper pins
    task automatic chk_out();
        repeat (6) @(posedge clk);
        for (int b = 0; b < 2; b++) begin
            chk(9'(nstb[b]), 9'(estb[b]));
            if (dir[b] != DIR_INPUT)
                chk({oe_n[b], b ? out1 : out0}, {~(pg & (arm[b][0] | ~wdog)), 8'(lat[b])});
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            sw <= 4'(k);
            base = {4'(k), 1'b0};
            wrb(0);
            wrb(1);
            u_host.bus(1'b1, base + 5'h02, 8'hFF, rdv, oe);
            chk_out();
        end
        dir <= 2'b01;
        in0 <= 8'($random(seed));
        wrb(0);
        u_host.bus(1'b0, base, 8'h00, rdv, oe);
        chk({oe, rdv}, {1'b0, in0});
        u_host.bus(1'b0, base + 5'h01, 8'h00, rdv, oe);
        chk({oe, 8'h00}, 9'h100);
        pg <= 1'b0;
        lat = '{0, 0};
        arm = '{0, 0};
        chk_out();
        u_host.bus(1'b0, base, 8'h00, rdv, oe);
        chk({oe, rdv}, {1'b0, in0});
        pg <= 1'b1;
        chk_out();
        wrb(1);
        chk_out();
        wdog <= 1'b0;
        wrb(1);
        pg <= 1'b0;
        chk_out();
        wrb(1);
        pg <= 1'b1;
        chk_out();
        end_of_test();
    end
endmodule // rcb_carrier_test
`default_nettype wire
